/* File: tbg_pkg.sv */
package tbg_pkg;

    // Register byte offsets on the bus
    localparam logic [7:0] OFS_PSC  = 8'h00;
    localparam logic [7:0] OFS_TB0  = 8'h04;
    localparam logic [7:0] OFS_TB1  = 8'h08;
    localparam logic [7:0] OFS_IEN  = 8'h0c;
    localparam logic [7:0] OFS_GEN  = 8'h10;
    localparam logic [7:0] OFS_FLG  = 8'h14;
    localparam logic [7:0] OFS_GFLG = 8'h18;
    localparam logic [7:0] OFS_HLIM = 8'h1c;
    localparam logic [7:0] OFS_LLIM = 8'h20;
    localparam logic [7:0] OFS_SVC  = 8'h24;

    // Widths and reset values
    localparam int         ADR_W     = 8;
    localparam int         DAT_W     = 32;
    localparam int         REG_W     = 8;
    localparam logic [7:0] RST_BYTE  = 8'h00;

    // Field positions
    localparam int PSC_SEL_W  = 2;
    localparam int TB_RUN_BIT = 7;
    localparam int TB_PER_W   = 3;
    localparam int FLG_TICK0  = 0;
    localparam int FLG_TICK1  = 1;
    localparam int FLG_FRAME  = 2;
    localparam int FLG_RAMP   = 3;
    localparam int FLG_W      = 4;
    localparam int SVC_REQ_BIT = 7;
    localparam int SVC_FULL_BIT = 6;

    // Time base figures
    localparam int         TB_CNT_W     = 15;
    localparam logic [2:0] TB_PER_MAX   = 3'h7;
    localparam logic [1:0] QUARTER_LAST = 2'h3;

    // Grouped interrupts
    localparam int GROUP_CNT = 6;
    localparam int LED_GROUP = 0;
    localparam int VEC_W     = 4;

    // Prescaler source codes; any code with bit 1 set picks sub clock
    typedef enum logic [1:0] {
        PSC_SYS     = 2'b00,
        PSC_QUARTER = 2'b01
    } tbg_psc_t;

    // Service vectors; group k uses VEC_GROUP0 + k
    localparam logic [3:0] VEC_TICK0  = 4'h0;
    localparam logic [3:0] VEC_TICK1  = 4'h1;
    localparam logic [3:0] VEC_GROUP0 = 4'h2;

    // Bus handshake states
    typedef enum logic {
        WB_IDLE = 1'b0,
        WB_ACK  = 1'b1
    } tbg_wb_state_t;

    // Interrupt enable register layout, global enable in bit 0
    typedef struct packed {
        logic rampEn;
        logic frameEn;
        logic tick1En;
        logic tick0En;
        logic globalEn;
    } tbg_ien_t;

    // Request presented to the core
    typedef struct packed {
        logic             req;
        logic [VEC_W-1:0] vector;
    } tbg_svc_t;

endpackage

/* File: tbg_prescaler.sv */
module tbg_prescaler (
    // Clock and reset
    input  wire logic       clock,
    input  wire logic       arst_n,
    // Source choice
    input  wire logic [1:0] pscSel,
    input  wire logic       subClockTick,
    // Prescaler clock as one-cycle enable
    output logic            pscTick
);

    logic [1:0] quarter_reg;
    logic [1:0] quarter_next;
    logic       tick_reg;
    logic       tick_next;

    // Choose system clock, a quarter of it or the sub clock
    always_comb begin
        quarter_next = quarter_reg + 2'h1;
        case (pscSel)
            tbg_pkg::PSC_SYS:     tick_next = 1'b1;
            tbg_pkg::PSC_QUARTER: tick_next =
                (quarter_reg == tbg_pkg::QUARTER_LAST);
            default:              tick_next = subClockTick;
        endcase
    end

    // Register stage
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            quarter_reg <= 2'h0;
            tick_reg    <= 1'b0;
        end else begin
            quarter_reg <= quarter_next;
            tick_reg    <= tick_next;
        end
    end

    assign pscTick = tick_reg;

endmodule // tbg_prescaler

/* File: tbg_tick_div.sv */
module tbg_tick_div #(
    parameter int CNT_W = tbg_pkg::TB_CNT_W
) (
    // Clock and reset
    input  wire logic       clock,
    input  wire logic       arst_n,
    // Control
    input  wire logic       run,
    input  wire logic [2:0] period,
    input  wire logic       pscTick,
    // One-cycle overflow pulse
    output logic            overflow
);

    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] cnt_next;
    logic [CNT_W-1:0] mask;
    logic             ovf_reg;
    logic             ovf_next;

    // Period 2^(8+code): low bits all ones at a tick means overflow
    always_comb begin
        mask     = {CNT_W{1'b1}} >> (tbg_pkg::TB_PER_MAX - period);
        cnt_next = cnt_reg;
        ovf_next = 1'b0;
        if (!run) begin
            cnt_next = '0;
        end else if (pscTick) begin
            cnt_next = cnt_reg + 1'b1;
            ovf_next = ((cnt_reg & mask) == mask);
        end
    end

    // Register stage
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            cnt_reg <= '0;
            ovf_reg <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            ovf_reg <= ovf_next;
        end
    end

    assign overflow = ovf_reg;

endmodule // tbg_tick_div

/* File: tbg_irq_top.sv */
// Summary of operation
// - Divider overflow sets its time base flag
// - Tick vector needs global, own enable, stack
// - Servicing tick clears its flag and global
// - Source code 00 sys, 01 quarter, 1x sub
// - Zero period is 2^(8+code) prescaler cycles
// - One period uses the same power encoding
// - Unimplemented register bits read as zero
// - Six groups fed by member sources, group 0 also by frame and ramp
// - Member flag set also sets group flag
// - Servicing group clears group flag, global
// - Frame flag set when frame completes
// - Frame vectors needs global, frame, group
// - Ramp flag set at high limit ramping up, low limit ramping down
// - Ramp vectors needs global, ramp, group
// - Flags stay set while interrupts blocked
// - Any flag rising raises wake pulse
//
// Local design decisions: register access over Wishbone and the placing of the registers.
module tbg_irq_top #(
    parameter int GROUPS = tbg_pkg::GROUP_CNT
) (
    // Clock and reset
    input  wire logic                      clock,
    input  wire logic                      arst_n,
    // Wishbone slave
    input  wire logic                      wb_cyc_i,
    input  wire logic                      wb_stb_i,
    input  wire logic                      wb_we_i,
    input  wire logic [tbg_pkg::ADR_W-1:0] wb_adr_i,
    input  wire logic [3:0]                wb_sel_i,
    input  wire logic [tbg_pkg::DAT_W-1:0] wb_dat_i,
    output logic      [tbg_pkg::DAT_W-1:0] wb_dat_o,
    output logic                           wb_ack_o,
    // Event sources
    input  wire logic                      subClockTick,
    input  wire logic                      frameDone,
    input  wire logic                      dutyStep,
    input  wire logic                      rampUp,
    input  wire logic [7:0]                duty,
    input  wire logic [GROUPS-1:0]         memberSet,
    // Core side
    input  wire logic                      stackFull,
    input  wire logic                      svcAck,
    output logic                           svcReq,
    output logic      [tbg_pkg::VEC_W-1:0] svcVector,
    output logic                           wakeUp
);

    tbg_pkg::tbg_wb_state_t      wbState_reg;
    tbg_pkg::tbg_wb_state_t      wbState_next;
    logic [tbg_pkg::DAT_W-1:0]   rdat_reg;
    logic [tbg_pkg::DAT_W-1:0]   rdat_next;
    logic [tbg_pkg::REG_W-1:0]   psc_reg;
    logic [tbg_pkg::REG_W-1:0]   psc_next;
    logic [tbg_pkg::REG_W-1:0]   tb0_reg;
    logic [tbg_pkg::REG_W-1:0]   tb0_next;
    logic [tbg_pkg::REG_W-1:0]   tb1_reg;
    logic [tbg_pkg::REG_W-1:0]   tb1_next;
    logic [tbg_pkg::REG_W-1:0]   hlim_reg;
    logic [tbg_pkg::REG_W-1:0]   hlim_next;
    logic [tbg_pkg::REG_W-1:0]   llim_reg;
    logic [tbg_pkg::REG_W-1:0]   llim_next;
    tbg_pkg::tbg_ien_t           ien_reg;
    tbg_pkg::tbg_ien_t           ien_next;
    logic [GROUPS-1:0]           gen_reg;
    logic [GROUPS-1:0]           gen_next;
    logic [tbg_pkg::FLG_W-1:0]   flg_reg;
    logic [tbg_pkg::FLG_W-1:0]   flg_next;
    logic [GROUPS-1:0]           gflg_reg;
    logic [GROUPS-1:0]           gflg_next;
    tbg_pkg::tbg_svc_t           svc_reg;
    tbg_pkg::tbg_svc_t           svc_next;
    logic                        wake_reg;
    logic                        wake_next;

    logic                        pscTick;
    logic                        ovf0;
    logic                        ovf1;
    logic                        wrHit;
    logic [tbg_pkg::REG_W-1:0]   wbyte;
    logic                        svcTake;
    logic                        frameSet;
    logic                        rampSet;
    logic [GROUPS-1:0]           grpSet;
    logic                        anyPend;
    logic [tbg_pkg::VEC_W-1:0]   pendVec;

    // Register value as seen by a read, spare bits zero
    function automatic logic [tbg_pkg::DAT_W-1:0] readMux(
        input logic [tbg_pkg::ADR_W-1:0] adr
    );
        logic [tbg_pkg::REG_W-1:0] v;
        v = tbg_pkg::RST_BYTE;
        case (adr)
            tbg_pkg::OFS_PSC:  v = psc_reg;
            tbg_pkg::OFS_TB0:  v = tb0_reg;
            tbg_pkg::OFS_TB1:  v = tb1_reg;
            tbg_pkg::OFS_IEN:  v = 8'(ien_reg);
            tbg_pkg::OFS_GEN:  v = 8'(gen_reg);
            tbg_pkg::OFS_FLG:  v = 8'(flg_reg);
            tbg_pkg::OFS_GFLG: v = 8'(gflg_reg);
            tbg_pkg::OFS_HLIM: v = hlim_reg;
            tbg_pkg::OFS_LLIM: v = llim_reg;
            tbg_pkg::OFS_SVC: begin
                v = 8'(svc_reg.vector);
                v[tbg_pkg::SVC_REQ_BIT]  = svc_reg.req;
                v[tbg_pkg::SVC_FULL_BIT] = stackFull;
            end
            default:           v = tbg_pkg::RST_BYTE;
        endcase
        return 32'(v);
    endfunction

    // Prescaler source
    tbg_prescaler u_psc (
        .clock        (clock),
        .arst_n       (arst_n),
        .pscSel       (psc_reg[tbg_pkg::PSC_SEL_W-1:0]),
        .subClockTick (subClockTick),
        .pscTick      (pscTick)
    );

    // Time base zero
    tbg_tick_div u_tb0 (
        .clock    (clock),
        .arst_n   (arst_n),
        .run      (tb0_reg[tbg_pkg::TB_RUN_BIT]),
        .period   (tb0_reg[tbg_pkg::TB_PER_W-1:0]),
        .pscTick  (pscTick),
        .overflow (ovf0)
    );

    // Time base one
    tbg_tick_div u_tb1 (
        .clock    (clock),
        .arst_n   (arst_n),
        .run      (tb1_reg[tbg_pkg::TB_RUN_BIT]),
        .period   (tb1_reg[tbg_pkg::TB_PER_W-1:0]),
        .pscTick  (pscTick),
        .overflow (ovf1)
    );

    // Bus handshake: ack one cycle after request, write at the ack edge
    always_comb begin
        wbState_next = tbg_pkg::WB_IDLE;
        rdat_next    = rdat_reg;
        if (wbState_reg == tbg_pkg::WB_IDLE && wb_cyc_i && wb_stb_i) begin
            wbState_next = tbg_pkg::WB_ACK;
            rdat_next    = wb_we_i ? '0 : readMux(wb_adr_i);
        end
        wrHit = (wbState_reg == tbg_pkg::WB_ACK) && wb_cyc_i
                && wb_stb_i && wb_we_i && wb_sel_i[0];
        wbyte = wb_dat_i[tbg_pkg::REG_W-1:0];
    end

    // Event detection and pending request choice
    always_comb begin
        svcTake  = svcAck && svc_reg.req;
        frameSet = frameDone;
        rampSet  = dutyStep &&
                   (rampUp ? (duty == hlim_reg)
                           : (duty == llim_reg));
        grpSet   = memberSet;
        grpSet[tbg_pkg::LED_GROUP] = memberSet[tbg_pkg::LED_GROUP]
            | (frameSet && ien_reg.frameEn)
            | (rampSet && ien_reg.rampEn);
        anyPend  = 1'b1;
        pendVec  = tbg_pkg::VEC_TICK0;
        if (flg_reg[tbg_pkg::FLG_TICK0] && ien_reg.tick0En) begin
            pendVec = tbg_pkg::VEC_TICK0;
        end else if (flg_reg[tbg_pkg::FLG_TICK1] && ien_reg.tick1En) begin
            pendVec = tbg_pkg::VEC_TICK1;
        end else begin
            anyPend = 1'b0;
            for (int k = GROUPS - 1; k >= 0; k--) begin
                if (gflg_reg[k] && gen_reg[k]) begin
                    anyPend = 1'b1;
                    pendVec = tbg_pkg::VEC_GROUP0 + 4'(k);
                end
            end
        end
    end

    // Configuration registers written by software
    always_comb begin
        psc_next  = psc_reg;
        tb0_next  = tb0_reg;
        tb1_next  = tb1_reg;
        hlim_next = hlim_reg;
        llim_next = llim_reg;
        gen_next  = gen_reg;
        ien_next  = ien_reg;
        if (wrHit) begin
            case (wb_adr_i)
                tbg_pkg::OFS_PSC:  psc_next =
                    {6'h00, wbyte[tbg_pkg::PSC_SEL_W-1:0]};
                tbg_pkg::OFS_TB0:  tb0_next = {wbyte[tbg_pkg::TB_RUN_BIT],
                    4'h0, wbyte[tbg_pkg::TB_PER_W-1:0]};
                tbg_pkg::OFS_TB1:  tb1_next = {wbyte[tbg_pkg::TB_RUN_BIT],
                    4'h0, wbyte[tbg_pkg::TB_PER_W-1:0]};
                tbg_pkg::OFS_HLIM: hlim_next = wbyte;
                tbg_pkg::OFS_LLIM: llim_next = wbyte;
                tbg_pkg::OFS_GEN:  gen_next = wbyte[GROUPS-1:0];
                tbg_pkg::OFS_IEN:  ien_next = wbyte[$bits(ien_reg)-1:0];
                default: ;
            endcase
        end
        if (svcTake) begin
            ien_next.globalEn = 1'b0;
        end
    end

    // Request flags: clear by write-one, by service, set wins last
    always_comb begin
        flg_next  = flg_reg;
        gflg_next = gflg_reg;
        if (wrHit && wb_adr_i == tbg_pkg::OFS_FLG) begin
            flg_next = flg_reg & ~wbyte[tbg_pkg::FLG_W-1:0];
        end
        if (wrHit && wb_adr_i == tbg_pkg::OFS_GFLG) begin
            gflg_next = gflg_reg & ~wbyte[GROUPS-1:0];
        end
        if (svcTake) begin
            if (svc_reg.vector == tbg_pkg::VEC_TICK0) begin
                flg_next[tbg_pkg::FLG_TICK0] = 1'b0;
            end else if (svc_reg.vector == tbg_pkg::VEC_TICK1) begin
                flg_next[tbg_pkg::FLG_TICK1] = 1'b0;
            end else begin
                for (int k = 0; k < GROUPS; k++) begin
                    if (svc_reg.vector == tbg_pkg::VEC_GROUP0 + 4'(k)) begin
                        gflg_next[k] = 1'b0;
                    end
                end
            end
        end
        if (ovf0) flg_next[tbg_pkg::FLG_TICK0] = 1'b1;
        if (ovf1) flg_next[tbg_pkg::FLG_TICK1] = 1'b1;
        if (frameSet) flg_next[tbg_pkg::FLG_FRAME] = 1'b1;
        if (rampSet) flg_next[tbg_pkg::FLG_RAMP] = 1'b1;
        gflg_next = gflg_next | grpSet;
        wake_next = |(flg_next & ~flg_reg)
                  | |(gflg_next & ~gflg_reg);
    end

    // Service request towards the core
    always_comb begin
        svc_next.req = ien_reg.globalEn && !stackFull
                       && anyPend && !svcTake;
        svc_next.vector = svc_reg.vector;
        if (!svc_reg.req || svcTake) begin
            svc_next.vector = pendVec;
        end
    end

    // Register stage
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            wbState_reg <= tbg_pkg::WB_IDLE;
            rdat_reg    <= '0;
            psc_reg     <= tbg_pkg::RST_BYTE;
            tb0_reg     <= tbg_pkg::RST_BYTE;
            tb1_reg     <= tbg_pkg::RST_BYTE;
            hlim_reg    <= tbg_pkg::RST_BYTE;
            llim_reg    <= tbg_pkg::RST_BYTE;
            ien_reg     <= '0;
            gen_reg     <= '0;
            flg_reg     <= '0;
            gflg_reg    <= '0;
            svc_reg     <= '0;
            wake_reg    <= 1'b0;
        end else begin
            wbState_reg <= wbState_next;
            rdat_reg    <= rdat_next;
            psc_reg     <= psc_next;
            tb0_reg     <= tb0_next;
            tb1_reg     <= tb1_next;
            hlim_reg    <= hlim_next;
            llim_reg    <= llim_next;
            ien_reg     <= ien_next;
            gen_reg     <= gen_next;
            flg_reg     <= flg_next;
            gflg_reg    <= gflg_next;
            svc_reg     <= svc_next;
            wake_reg    <= wake_next;
        end
    end

    // Outputs straight from flip-flops
    assign wb_ack_o  = (wbState_reg == tbg_pkg::WB_ACK);
    assign wb_dat_o  = rdat_reg;
    assign svcReq    = svc_reg.req;
    assign svcVector = svc_reg.vector;
    assign wakeUp    = wake_reg;

endmodule // tbg_irq_top

/* File: tbg_irq_monitor.sv */
module tbg_irq_monitor #(
    parameter int GROUPS = tbg_pkg::GROUP_CNT
) (
    // Clock and reset
    input wire logic                      clock,
    input wire logic                      arst_n,
    // Wishbone slave
    input wire logic                      wb_cyc_i,
    input wire logic                      wb_stb_i,
    input wire logic                      wb_we_i,
    input wire logic [tbg_pkg::ADR_W-1:0] wb_adr_i,
    input wire logic [3:0]                wb_sel_i,
    input wire logic [tbg_pkg::DAT_W-1:0] wb_dat_i,
    input wire logic [tbg_pkg::DAT_W-1:0] wb_dat_o,
    input wire logic                      wb_ack_o,
    // Event sources
    input wire logic                      subClockTick,
    input wire logic                      frameDone,
    input wire logic                      dutyStep,
    input wire logic                      rampUp,
    input wire logic [7:0]                duty,
    input wire logic [GROUPS-1:0]         memberSet,
    // Core side
    input wire logic                      stackFull,
    input wire logic                      svcAck,
    input wire logic                      svcReq,
    input wire logic [tbg_pkg::VEC_W-1:0] svcVector,
    input wire logic                      wakeUp
);
    default clocking monClk @(posedge clock);
    endclocking
    default disable iff (!arst_n);

    // Bus answers once, one cycle after the request is taken
    a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("bus ack held longer than one cycle");
    a_ack_after_req: assert property
        (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("bus request not answered in one cycle");
    a_ack_needs_req: assert property
        (wb_ack_o |-> $past(wb_cyc_i) && $past(wb_stb_i))
        else $error("bus ack without a request");

    // Read data padding
    a_upper_zero: assert property
        (wb_ack_o && !wb_we_i |-> wb_dat_o[31:8] == 24'h0)
        else $error("upper read data bits not zero");
    a_psc_pad_zero: assert property (wb_ack_o && !wb_we_i &&
        wb_adr_i == tbg_pkg::OFS_PSC |-> wb_dat_o[7:2] == 6'h0)
        else $error("prescaler select padding not zero");
    a_ctl_pad_zero: assert property (wb_ack_o && !wb_we_i &&
        (wb_adr_i == tbg_pkg::OFS_TB0 || wb_adr_i == tbg_pkg::OFS_TB1)
        |-> wb_dat_o[6:3] == 4'h0)
        else $error("time base control padding not zero");

    // Service request handling
    a_full_blocks: assert property ($rose(svcReq) |-> !$past(stackFull))
        else $error("service request raised while stack full");
    a_svc_clears: assert property (svcReq && svcAck |=> !svcReq)
        else $error("service request stayed after being taken");
    a_vector_frozen: assert property
        (svcReq && !svcAck |=> !svcReq || $stable(svcVector))
        else $error("vector changed while request pending");
    a_vector_range: assert property
        (svcReq |-> svcVector <= tbg_pkg::VEC_GROUP0 + GROUPS - 1)
        else $error("vector outside the implemented set");
endmodule // tbg_irq_monitor

bind tbg_irq_top tbg_irq_monitor #(.GROUPS(GROUPS)) uMonitor (
    .clock(clock), .arst_n(arst_n), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .subClockTick(subClockTick),
    .frameDone(frameDone), .dutyStep(dutyStep), .rampUp(rampUp),
    .duty(duty), .memberSet(memberSet), .stackFull(stackFull),
    .svcAck(svcAck), .svcReq(svcReq), .svcVector(svcVector),
    .wakeUp(wakeUp)
);

/* File: tbg_testbench.sv */
module testbench;
    timeunit 1ns;
    timeprecision 1ps;

    // Design connections
    logic        clock;
    logic        arst_n;
    logic        wbCyc;
    logic        wbStb;
    logic        wbWe;
    logic [7:0]  wbAdr;
    logic [3:0]  wbSel;
    logic [31:0] wbDatI;
    logic [31:0] wbDatO;
    logic        wbAck;
    logic        subClockTick;
    logic        frameDone;
    logic        dutyStep;
    logic        rampUp;
    logic [7:0]  duty;
    logic [5:0]  memberSet;
    logic        stackFull;
    logic        svcAck;
    logic        svcReq;
    logic [3:0]  svcVector;
    logic        wakeUp;
    // Bench state
    logic [1:0]  subCount;
    int          cycleCount;
    int          n_mismatch;
    int          samples_checked;

    tbg_irq_top DUT (
        .clock(clock), .arst_n(arst_n), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
        .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel),
        .wb_dat_i(wbDatI), .wb_dat_o(wbDatO), .wb_ack_o(wbAck),
        .subClockTick(subClockTick), .frameDone(frameDone),
        .dutyStep(dutyStep), .rampUp(rampUp), .duty(duty),
        .memberSet(memberSet), .stackFull(stackFull), .svcAck(svcAck),
        .svcReq(svcReq), .svcVector(svcVector), .wakeUp(wakeUp)
    );

    // Clock generator
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    // Sub clock pulse every third cycle, and a cycle count
    always @(posedge clock) begin
        subCount     <= (subCount == 2'h2) ? 2'h0 : subCount + 2'h1;
        subClockTick <= (subCount == 2'h2);
        cycleCount   <= cycleCount + 1;
    end

    // Verdict and end of run
    task automatic complete_run();
        $display("Mismatches %0d, checks %0d", n_mismatch, samples_checked);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Compare and count
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // A wait ran out
    task automatic timed_out();
        n_mismatch++;
        $display("ERROR at %0t: wait ran out, seen %h expected %h", $time,
                 1'b0, 1'b1);
        complete_run();
    endtask

    // One classic Wishbone cycle, held until ack is sampled
    task automatic bus(input logic [7:0] a, input logic w,
                       input logic [7:0] d, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clock);
        wbCyc  <= 1'b1;
        wbStb  <= 1'b1;
        wbWe   <= w;
        wbAdr  <= a;
        wbSel  <= 4'hf;
        wbDatI <= {24'h0, d};
        do begin
            @(posedge clock);
            n++;
        end while (wbAck !== 1'b1 && n < 20);
        if (n >= 20) timed_out();
        q = wbDatO;
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
        wbWe  <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] q;
        bus(a, 1'b1, d, q);
    endtask

    task automatic rd_check(input logic [7:0] a, input logic [7:0] e);
        logic [31:0] q;
        bus(a, 1'b0, 8'h00, q);
        check(q, {24'h0, e});
    endtask

    // Waits for a wake pulse and returns the cycle it was seen in
    task automatic wait_wake(output int t);
        int n;
        for (n = 0; n < 40000; n++) begin
            @(negedge clock);
            if (wakeUp === 1'b1) break;
        end
        if (n >= 40000) timed_out();
        t = cycleCount;
    endtask

    task automatic wait_req();
        int n;
        for (n = 0; n < 20; n++) begin
            @(negedge clock);
            if (svcReq === 1'b1) break;
        end
        if (n >= 20) timed_out();
    endtask

    // Core takes the pending request
    task automatic take_svc();
        @(posedge clock);
        svcAck <= 1'b1;
        @(posedge clock);
        svcAck <= 1'b0;
    endtask

    // Period between two overflows, flag cleared in between
    task automatic period_run(input logic [7:0] src, input logic [7:0] adr,
                              input logic [7:0] ctl, input int expCycles);
        int t0;
        int t1;
        wr(tbg_pkg::OFS_PSC, src);
        wr(adr, ctl);
        wait_wake(t0);
        wr(tbg_pkg::OFS_FLG, 8'h0f);
        wait_wake(t1);
        check(t1 - t0, expCycles);
        wr(adr, 8'h00);
        wr(tbg_pkg::OFS_FLG, 8'h0f);
    endtask

    // Reset values, padding bits, unmapped place, stopped time base
    task automatic reg_scenario();
        rd_check(tbg_pkg::OFS_TB0, 8'h00);
        rd_check(tbg_pkg::OFS_TB1, 8'h00);
        wr(tbg_pkg::OFS_PSC, 8'hff);
        rd_check(tbg_pkg::OFS_PSC, 8'h03);
        wr(tbg_pkg::OFS_TB0, 8'hff);
        rd_check(tbg_pkg::OFS_TB0, 8'h87);
        wr(tbg_pkg::OFS_TB1, 8'hff);
        rd_check(tbg_pkg::OFS_TB1, 8'h87);
        wr(tbg_pkg::OFS_PSC, 8'h00);
        wr(tbg_pkg::OFS_TB0, 8'h00);
        wr(tbg_pkg::OFS_TB1, 8'h00);
        wr(8'h3c, 8'hff);
        rd_check(8'h3c, 8'h00);
        repeat (300) @(posedge clock);
        rd_check(tbg_pkg::OFS_FLG, 8'h00);
    endtask

    // Tick service held off by a full stack, then taken
    task automatic tick_scenario();
        int t;
        stackFull <= 1'b1;
        wr(tbg_pkg::OFS_IEN, 8'h03);
        wr(tbg_pkg::OFS_TB0, 8'h80);
        wait_wake(t);
        repeat (4) @(negedge clock);
        check(svcReq, 1'b0);
        rd_check(tbg_pkg::OFS_FLG, 8'h01);
        rd_check(tbg_pkg::OFS_SVC, 8'h40);
        @(posedge clock);
        stackFull <= 1'b0;
        wait_req();
        check(svcVector, tbg_pkg::VEC_TICK0);
        take_svc();
        rd_check(tbg_pkg::OFS_FLG, 8'h00);
        rd_check(tbg_pkg::OFS_IEN, 8'h02);
        wr(tbg_pkg::OFS_TB0, 8'h00);
    endtask

    // Each group raised by a member source and serviced
    task automatic group_scenario();
        int k;
        for (k = 0; k < 6; k++) begin
            wr(tbg_pkg::OFS_GEN, 8'h01 << k);
            wr(tbg_pkg::OFS_IEN, 8'h01);
            memberSet <= 6'h01 << k;
            @(posedge clock);
            memberSet <= 6'h00;
            wait_req();
            check(svcVector, tbg_pkg::VEC_GROUP0 + k);
            rd_check(tbg_pkg::OFS_GFLG, 8'h01 << k);
            take_svc();
            rd_check(tbg_pkg::OFS_GFLG, 8'h00);
            rd_check(tbg_pkg::OFS_IEN, 8'h00);
        end
    endtask

    // One duty step, then the ramp flag is read and cleared
    task automatic ramp_step(input logic up, input logic [7:0] d,
                             input logic [7:0] e);
        dutyStep <= 1'b1;
        rampUp   <= up;
        duty     <= d;
        @(posedge clock);
        dutyStep <= 1'b0;
        rd_check(tbg_pkg::OFS_FLG, e);
        wr(tbg_pkg::OFS_FLG, 8'h08);
    endtask

    // Frame and ramp events through group zero
    task automatic led_scenario();
        wr(tbg_pkg::OFS_GEN, 8'h01);
        wr(tbg_pkg::OFS_IEN, 8'h09);
        frameDone <= 1'b1;
        @(posedge clock);
        frameDone <= 1'b0;
        wait_req();
        check(svcVector, tbg_pkg::VEC_GROUP0);
        take_svc();
        rd_check(tbg_pkg::OFS_FLG, 8'h04);
        rd_check(tbg_pkg::OFS_GFLG, 8'h00);
        wr(tbg_pkg::OFS_FLG, 8'h04);
        rd_check(tbg_pkg::OFS_FLG, 8'h00);
        wr(tbg_pkg::OFS_HLIM, 8'h40);
        wr(tbg_pkg::OFS_LLIM, 8'h10);
        wr(tbg_pkg::OFS_IEN, 8'h11);
        ramp_step(1'b1, 8'h3f, 8'h00);
        ramp_step(1'b0, 8'h40, 8'h00);
        ramp_step(1'b0, 8'h10, 8'h08);
        ramp_step(1'b1, 8'h40, 8'h08);
        wait_req();
        check(svcVector, tbg_pkg::VEC_GROUP0);
        take_svc();
    endtask

    // Main sequence
    initial begin
        arst_n = 1'b0;
        wbCyc = 1'b0;
        wbStb = 1'b0;
        wbWe = 1'b0;
        wbAdr = 8'h00;
        wbSel = 4'h0;
        wbDatI = 32'h0000_0000;
        subClockTick = 1'b0;
        frameDone = 1'b0;
        dutyStep = 1'b0;
        rampUp = 1'b0;
        duty = 8'h00;
        memberSet = 6'h00;
        stackFull = 1'b0;
        svcAck = 1'b0;
        subCount = 2'h0;
        cycleCount = 0;
        n_mismatch = 0;
        samples_checked = 0;
        repeat (10) @(posedge clock);
        arst_n <= 1'b1;
        reg_scenario();
        tick_scenario();
        group_scenario();
        led_scenario();
        period_run(8'h00, tbg_pkg::OFS_TB0, 8'h80, 256);
        period_run(8'h01, tbg_pkg::OFS_TB0, 8'h80, 1024);
        period_run(8'h02, tbg_pkg::OFS_TB0, 8'h80, 768);
        period_run(8'h03, tbg_pkg::OFS_TB0, 8'h81, 1536);
        period_run(8'h00, tbg_pkg::OFS_TB1, 8'h82, 1024);
        period_run(8'h00, tbg_pkg::OFS_TB1, 8'h87, 32768);
        complete_run();
    end
endmodule // testbench
